// ---- verilog/pio_pkg.sv ----
// Purpose: shared constants and types for the port latch and drive block
// Assumes: one system clock, special-function register access from the core
// Notes: port slot 0 is port 3, slot 1 is port 4, slot 2 is port 5
package pio_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int PORT_W = 8;
  localparam int N_PORT = 3;
  localparam int IDX_P3 = 0;
  localparam int IDX_P4 = 1;
  localparam int IDX_P5 = 2;

  // ************************************************************
  // register addresses and page
  // ************************************************************
  localparam logic [7:0] ADDR_P4_MODE = 8'h9C;
  localparam logic [7:0] ADDR_P5_MODE = 8'h9D;
  localparam logic [7:0] ADDR_P2_MODE = 8'hA6;
  localparam logic [7:0] ADDR_P3_LATCH = 8'hB0;
  localparam logic [7:0] ADDR_P4_LATCH = 8'hC8;
  localparam logic [7:0] ADDR_P5_LATCH = 8'hD8;
  localparam logic [7:0] PAGE_HIGH = 8'h0F;

  // ************************************************************
  // reset values and field positions
  // ************************************************************
  localparam logic [7:0] LATCH_RST = 8'hFF;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam int BIT_WR_STB = 7;
  localparam int BIT_RD_STB = 6;
  localparam int BIT_ALE = 5;

  // decoded register targets
  typedef enum logic [2:0] {
    PIO_REG_NONE = 3'b000,
    PIO_REG_P3 = 3'b001,
    PIO_REG_P4 = 3'b010,
    PIO_REG_P5 = 3'b011,
    PIO_REG_P2M = 3'b100,
    PIO_REG_P4M = 3'b101,
    PIO_REG_P5M = 3'b110
  } pio_reg_t;

endpackage

// ---- verilog/pio_drv_if.sv ----
// Purpose: carries one port's latch, mode and override set to its pin driver
// Assumes: driver side is purely combinational
// Notes: results are registered by the owner of the ctl modport
`timescale 1ns/10ps
interface pio_drv_if #(parameter int W = 8);
  logic [W-1:0] latch;
  logic [W-1:0] mode;
  logic [W-1:0] force_od;
  logic [W-1:0] ovr_en;
  logic [W-1:0] ovr_val;
  logic [W-1:0] ovr_hiz;
  logic pull_off;
  logic [W-1:0] out;
  logic [W-1:0] oe_n;
  logic [W-1:0] pu;
  modport ctl (output latch, mode, force_od, ovr_en, ovr_val, ovr_hiz,
    pull_off, input out, oe_n, pu);
  modport drv (input latch, mode, force_od, ovr_en, ovr_val, ovr_hiz,
    pull_off, output out, oe_n, pu);
endinterface

// ---- verilog/pio_pin_sync.sv ----
// Purpose: three-stage pin input filter
// Assumes: pins are asynchronous to clk_sys
// Notes: a change counts once stages two and three agree
`timescale 1ns/10ps
module pio_pin_sync #(parameter int W = 8) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pin side
  input wire logic [W-1:0] pin_raw,
  // filtered level
  output logic [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } pio_sync_st_t;

  pio_sync_st_t st;
  pio_sync_st_t next_st;

  // stage one feeds only stage two
  always_comb begin
    next_st = st;
    next_st.s1 = pin_raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // take agreed value, hold while stages disagree
    next_st.lvl = (st.s2 & st.s3) | (st.lvl & (st.s2 | st.s3));
  end

  // pins idle high under the pull-ups, so reset to ones
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.lvl;
endmodule

// ---- verilog/pio_pin_drive.sv ----
// Purpose: per-pin drive style, level and pull-up decision
// Assumes: inputs settle within one clk_sys cycle
// Notes: result is registered by the caller
`timescale 1ns/10ps
module pio_pin_drive #(parameter int W = 8) (
  // control and results
  pio_drv_if.drv bus
);
  logic [W-1:0] val;
  logic [W-1:0] od;
  logic [W-1:0] drive;

  // memory interface override beats the latch; style bits untouched
  always_comb begin
    val = (bus.ovr_en & bus.ovr_val) | (~bus.ovr_en & bus.latch);
    od = bus.force_od | ~bus.mode;
    // a one in open-drain style releases the pin
    drive = ~bus.ovr_hiz & (~val | ~od);
    bus.out = val;
    bus.oe_n = ~drive;
    // never let a pin fight its own pull-up while pulling low
    bus.pu = {W{~bus.pull_off}} & ~(drive & ~val);
  end
endmodule

// ---- verilog/pio_port_io.sv ----
// Purpose: port 3/4/5 data latches, drive-mode registers and pin control
// Assumes: core gives byte and bit accesses with address, page and rmw flag
// Notes: pin outputs follow a register write after two clk_sys edges
//
// Notes on behaviour
// - mode bit clear open-drain, set push-pull
// - all mode registers reset to zero
// - latch write sets pin output level
// - open-drain one floats, push-pull one drives
// - normal read returns live pin level
// - read-modify-write read returns latch contents
// - high port latches take byte and bit
// - registers and inputs stay active without pins
// - global disable turns off every weak pull-up
// - pull-up off on pins driving low
// - memory interface overrides latches during access
// - styles kept, read floats the data bus
// - port 3 carries address/data or data byte
// - port 4 top pins carry memory strobes
// - port 5 carries upper address, non-multiplexed
// - two-wire and shift-mode receive pins open-drain
// - port 3 latch reachable from every page
`timescale 1ns/10ps
module pio_port_io (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register access from the core
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic sfr_bit_val,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  // configuration held elsewhere
  input wire logic pullup_global_disable,
  input wire logic [7:0] port3_drive_mode,
  input wire logic [pio_pkg::N_PORT-1:0][7:0] force_open_drain,
  // memory interface on the high ports
  input wire logic external_memory_interface_active,
  input wire logic external_memory_interface_mux,
  input wire logic external_memory_interface_read,
  input wire logic [7:0] external_memory_interface_ad,
  input wire logic [7:0] external_memory_interface_addr_hi,
  input wire logic external_memory_interface_wr_n,
  input wire logic external_memory_interface_rd_n,
  input wire logic external_memory_interface_ale,
  // pins
  input wire logic [pio_pkg::N_PORT-1:0][7:0] pin_in,
  output logic [pio_pkg::N_PORT-1:0][7:0] pin_out,
  output logic [pio_pkg::N_PORT-1:0][7:0] pin_oe_n,
  output logic [pio_pkg::N_PORT-1:0][7:0] pin_pu,
  // port 2 style for the port 2 driver
  output logic [7:0] port2_drive_mode
);
  import pio_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [N_PORT-1:0][7:0] latch;
    logic [7:0] p2_mode;
    logic [7:0] p4_mode;
    logic [7:0] p5_mode;
    logic [7:0] rdata;
    logic rvalid;
    logic [N_PORT-1:0][7:0] pout;
    logic [N_PORT-1:0][7:0] poe_n;
    logic [N_PORT-1:0][7:0] ppu;
  } pio_top_st_t;

  localparam pio_top_st_t ST_RST = '{
    latch: {N_PORT{LATCH_RST}},
    p2_mode: MODE_RST,
    p4_mode: MODE_RST,
    p5_mode: MODE_RST,
    rdata: BYTE_ZERO,
    rvalid: 1'b0,
    pout: {N_PORT{BYTE_ONES}},
    poe_n: {N_PORT{BYTE_ONES}},
    ppu: {N_PORT{BYTE_ONES}}
  };

  pio_top_st_t st;
  pio_top_st_t next_st;

  // ************************************************************
  // address decode
  // ************************************************************
  // port 3 latch ignores the page; everything else lives on page F
  function automatic pio_reg_t reg_of(input logic [7:0] a,
                                      input logic [7:0] pg);
    reg_of = PIO_REG_NONE;
    if (a == ADDR_P3_LATCH) begin
      reg_of = PIO_REG_P3;
    end else if (pg == PAGE_HIGH) begin
      case (a)
        ADDR_P4_LATCH: reg_of = PIO_REG_P4;
        ADDR_P5_LATCH: reg_of = PIO_REG_P5;
        ADDR_P2_MODE: reg_of = PIO_REG_P2M;
        ADDR_P4_MODE: reg_of = PIO_REG_P4M;
        ADDR_P5_MODE: reg_of = PIO_REG_P5M;
        default: reg_of = PIO_REG_NONE;
      endcase
    end
  endfunction

  pio_reg_t sel;
  assign sel = reg_of(sfr_addr, sfr_page);

  // ************************************************************
  // per-port pin filter and driver
  // ************************************************************
  logic [N_PORT-1:0][7:0] pin_lvl;
  logic [N_PORT-1:0][7:0] mode_of;
  logic [N_PORT-1:0][7:0] ovr_en;
  logic [N_PORT-1:0][7:0] ovr_val;
  logic [N_PORT-1:0][7:0] ovr_hiz;
  logic [N_PORT-1:0][7:0] drv_out;
  logic [N_PORT-1:0][7:0] drv_oe_n;
  logic [N_PORT-1:0][7:0] drv_pu;

  // style bits per slot
  assign mode_of[IDX_P3] = port3_drive_mode;
  assign mode_of[IDX_P4] = st.p4_mode;
  assign mode_of[IDX_P5] = st.p5_mode;

  genvar g;
  generate
    for (g = 0; g < N_PORT; g++) begin : g_port
      pio_drv_if #(.W(PORT_W)) u_if ();

      // input path stays live even when the port has no pins
      pio_pin_sync #(.W(PORT_W)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_raw(pin_in[g]),
        .level(pin_lvl[g])
      );

      pio_pin_drive #(.W(PORT_W)) u_drv (
        .bus(u_if.drv)
      );

      // hand this slot's controls to the driver
      assign u_if.latch = st.latch[g];
      assign u_if.mode = mode_of[g];
      assign u_if.force_od = force_open_drain[g];
      assign u_if.ovr_en = ovr_en[g];
      assign u_if.ovr_val = ovr_val[g];
      assign u_if.ovr_hiz = ovr_hiz[g];
      assign u_if.pull_off = pullup_global_disable;
      assign drv_out[g] = u_if.out;
      assign drv_oe_n[g] = u_if.oe_n;
      assign drv_pu[g] = u_if.pu;
    end
  endgenerate

  // ************************************************************
  // memory interface takeover
  // ************************************************************
  // only pins the interface owns are overridden; others keep latches
  always_comb begin
    ovr_en = '0;
    ovr_val = '0;
    ovr_hiz = '0;
    if (external_memory_interface_active) begin
      // port 3: address/data or data byte
      ovr_en[IDX_P3] = BYTE_ONES;
      ovr_val[IDX_P3] = external_memory_interface_ad;
      // a read floats the data bus only
      ovr_hiz[IDX_P3] = external_memory_interface_read ? BYTE_ONES : BYTE_ZERO;
      // port 4 top pins: strobes; latch pulse only when multiplexed
      ovr_en[IDX_P4][BIT_WR_STB] = 1'b1;
      ovr_en[IDX_P4][BIT_RD_STB] = 1'b1;
      ovr_en[IDX_P4][BIT_ALE] = external_memory_interface_mux;
      ovr_val[IDX_P4][BIT_WR_STB] = external_memory_interface_wr_n;
      ovr_val[IDX_P4][BIT_RD_STB] = external_memory_interface_rd_n;
      ovr_val[IDX_P4][BIT_ALE] = external_memory_interface_ale;
      // port 5: upper address in non-multiplexed mode
      ovr_en[IDX_P5] = external_memory_interface_mux ? BYTE_ZERO : BYTE_ONES;
      ovr_val[IDX_P5] = external_memory_interface_addr_hi;
    end
  end

  // ************************************************************
  // register writes, reads and pin registers
  // ************************************************************
  logic [1:0] lidx;
  logic is_latch;

  // latch slot for the decoded target
  always_comb begin
    is_latch = 1'b1;
    case (sel)
      PIO_REG_P3: lidx = 2'(IDX_P3);
      PIO_REG_P4: lidx = 2'(IDX_P4);
      PIO_REG_P5: lidx = 2'(IDX_P5);
      default: begin
        lidx = 2'(IDX_P3);
        is_latch = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    // byte writes
    if (sfr_wr) begin
      if (is_latch) begin
        next_st.latch[lidx] = sfr_wdata;
      end
      case (sel)
        PIO_REG_P2M: next_st.p2_mode = sfr_wdata;
        PIO_REG_P4M: next_st.p4_mode = sfr_wdata;
        PIO_REG_P5M: next_st.p5_mode = sfr_wdata;
        default: next_st.p2_mode = st.p2_mode;
      endcase
    end
    // bit writes reach only the bit-addressable latches
    if (sfr_bit_wr && is_latch) begin
      next_st.latch[lidx][sfr_bit_sel] = sfr_bit_val;
    end
    // reads answer one cycle later; unmapped reads give zero
    next_st.rvalid = sfr_rd;
    next_st.rdata = BYTE_ZERO;
    if (sfr_rd) begin
      case (sel)
        PIO_REG_P3, PIO_REG_P4, PIO_REG_P5: begin
          // rmw reads see the latch, others the filtered pin
          next_st.rdata = sfr_rmw ? st.latch[lidx] : pin_lvl[lidx];
        end
        PIO_REG_P2M: next_st.rdata = st.p2_mode;
        PIO_REG_P4M: next_st.rdata = st.p4_mode;
        PIO_REG_P5M: next_st.rdata = st.p5_mode;
        default: next_st.rdata = BYTE_ZERO;
      endcase
    end
    // pins registered so every output leaves a flip-flop
    next_st.pout = drv_out;
    next_st.poe_n = drv_oe_n;
    next_st.ppu = drv_pu;
  end

  // reset to latches high and every port 4 and port 5 pin open-drain
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign sfr_rdata = st.rdata;
  assign sfr_rvalid = st.rvalid;
  assign pin_out = st.pout;
  assign pin_oe_n = st.poe_n;
  assign pin_pu = st.ppu;
  assign port2_drive_mode = st.p2_mode;

  // ************************************************************
  // checks
  // ************************************************************
  a_mode_reset: assert property (@(posedge clk_sys)
    !rst_n |=> (st.p2_mode == MODE_RST) && (st.p4_mode == MODE_RST)
      && (st.p5_mode == MODE_RST))
    else $error("mode register not cleared by reset");

  a_latch_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_wr && !sfr_bit_wr && (sfr_addr == ADDR_P3_LATCH)
      |=> st.latch[IDX_P3] == $past(sfr_wdata))
    else $error("port 3 latch did not take the written byte");

  a_bit_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_bit_wr && !sfr_wr && (sfr_addr == ADDR_P4_LATCH) && (sfr_page == PAGE_HIGH)
      |=> st.latch[IDX_P4][$past(sfr_bit_sel)] == $past(sfr_bit_val))
    else $error("port 4 bit write lost");

  a_page_guard: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sfr_wr || sfr_bit_wr) && (sfr_page != PAGE_HIGH)
      && (sfr_addr == ADDR_P5_LATCH) |=> $stable(st.latch[IDX_P5]))
    else $error("port 5 latch written from a foreign page");

  a_rmw_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_rd && sfr_rmw && (sfr_addr == ADDR_P3_LATCH)
      |=> sfr_rvalid && (sfr_rdata == $past(st.latch[IDX_P3])))
    else $error("rmw read did not return the latch");

  a_pin_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_rd && !sfr_rmw && (sfr_addr == ADDR_P4_LATCH) && (sfr_page == PAGE_HIGH)
      |=> sfr_rdata == $past(pin_lvl[IDX_P4]))
    else $error("normal read did not return the pin level");

  a_no_fight: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (~pin_oe_n & ~pin_out & pin_pu) == '0)
    else $error("pull-up left on a pin driven low");

  a_pud_global: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pullup_global_disable ##1 pullup_global_disable |-> pin_pu == '0)
    else $error("pull-up on while globally disabled");

  a_od_float: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !external_memory_interface_active && (st.latch[IDX_P4][0] == 1'b1) && (st.p4_mode[0] == 1'b0)
      |=> pin_oe_n[IDX_P4][0])
    else $error("open-drain one was driven");

  a_strobe_take: assert property (@(posedge clk_sys) disable iff (!rst_n)
    external_memory_interface_active |=> pin_out[IDX_P4][BIT_WR_STB] == $past(external_memory_interface_wr_n))
    else $error("write strobe not on port 4 pin 7");

  a_read_float: assert property (@(posedge clk_sys) disable iff (!rst_n)
    external_memory_interface_active && external_memory_interface_read |=> pin_oe_n[IDX_P3] == BYTE_ONES)
    else $error("data bus driven during external read");

endmodule

// ---- verification/pio_board.sv ----
// Purpose: board around the port pins: pads, weak pull-ups, outside drivers
// Assumes: outside drivers are only enabled where the pad is released
// Notes: an undriven pin with no pull-up toggles every cycle
`timescale 1ns/10ps
module pio_board (
  // clock
  input wire logic clk_sys,
  // pad side
  input wire logic [pio_pkg::N_PORT-1:0][7:0] pin_out,
  input wire logic [pio_pkg::N_PORT-1:0][7:0] pin_oe_n,
  input wire logic [pio_pkg::N_PORT-1:0][7:0] pin_pu,
  // outside drivers
  input wire logic [pio_pkg::N_PORT-1:0][7:0] ext_en,
  input wire logic [pio_pkg::N_PORT-1:0][7:0] ext_val,
  // resolved wire level
  output logic [pio_pkg::N_PORT-1:0][7:0] pin_lvl
);
  import pio_pkg::*;
  logic [N_PORT-1:0][7:0] held;

  // ************************************************************
  // wire resolution
  // ************************************************************
  // floating pins never hold a steady level, so a stale read shows up
  always_comb begin
    for (int p = 0; p < N_PORT; p++) begin
      for (int b = 0; b < PORT_W; b++) begin
        if (!pin_oe_n[p][b]) begin
          pin_lvl[p][b] = pin_out[p][b];
        end else if (ext_en[p][b]) begin
          pin_lvl[p][b] = ext_val[p][b];
        end else if (pin_pu[p][b]) begin
          pin_lvl[p][b] = 1'b1;
        end else begin
          pin_lvl[p][b] = ~held[p][b];
        end
      end
    end
  end

  // last level seen on each wire
  always_ff @(posedge clk_sys) begin
    held <= pin_lvl;
  end
endmodule

// ---- verification/pio_port_io_tb.sv ----
// Purpose: self-checking bench for the port latch and drive block
// Assumes: inputs change on the falling edge, outputs read there too
// Notes: pin reads wait out the three-stage input filter
`timescale 1ns/10ps
module pio_port_io_tb;
  import pio_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_page = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_bit_wr = 1'b0;
  logic [2:0] sfr_bit_sel = 3'h0;
  logic sfr_bit_val = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic sfr_rmw = 1'b0;
  logic [7:0] sfr_rdata;
  logic sfr_rvalid;
  logic pullup_global_disable = 1'b0;
  logic [7:0] port3_drive_mode = 8'h00;
  logic [N_PORT-1:0][7:0] force_open_drain = '0;
  logic external_memory_interface_active = 1'b0;
  logic external_memory_interface_mux = 1'b0;
  logic external_memory_interface_read = 1'b0;
  logic [7:0] external_memory_interface_ad = 8'h00;
  logic [7:0] external_memory_interface_addr_hi = 8'h00;
  logic external_memory_interface_wr_n = 1'b1;
  logic external_memory_interface_rd_n = 1'b1;
  logic external_memory_interface_ale = 1'b0;
  logic [N_PORT-1:0][7:0] pin_in;
  logic [N_PORT-1:0][7:0] pin_out;
  logic [N_PORT-1:0][7:0] pin_oe_n;
  logic [N_PORT-1:0][7:0] pin_pu;
  logic [7:0] port2_drive_mode;
  logic [N_PORT-1:0][7:0] ext_en = '0;
  logic [N_PORT-1:0][7:0] ext_val = '0;
  int miscompares = 0;
  int check_count = 0;

  pio_port_io dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val), .sfr_wdata(sfr_wdata),
    .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
    .pullup_global_disable(pullup_global_disable), .port3_drive_mode(port3_drive_mode),
    .force_open_drain(force_open_drain), .external_memory_interface_active(external_memory_interface_active), .external_memory_interface_mux(external_memory_interface_mux),
    .external_memory_interface_read(external_memory_interface_read), .external_memory_interface_ad(external_memory_interface_ad), .external_memory_interface_addr_hi(external_memory_interface_addr_hi),
    .external_memory_interface_wr_n(external_memory_interface_wr_n), .external_memory_interface_rd_n(external_memory_interface_rd_n), .external_memory_interface_ale(external_memory_interface_ale), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pu(pin_pu),
    .port2_drive_mode(port2_drive_mode));

  pio_board board (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pu(pin_pu), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_in));

  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;

  // ************************************************************
  // access tasks and checks
  // ************************************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_page = pg;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask

  task automatic bwr(input logic [7:0] a, input logic [7:0] pg, input logic [2:0] s,
                     input logic v);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_page = pg;
    sfr_bit_sel = s;
    sfr_bit_val = v;
    sfr_bit_wr = 1'b1;
    @(negedge clk_sys);
    sfr_bit_wr = 1'b0;
  endtask

  // answer stands for the cycle right after the taking edge
  task automatic rdchk(input logic [7:0] a, input logic [7:0] pg, input logic rmw,
                       input logic [7:0] exp);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_page = pg;
    sfr_rmw = rmw;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    sfr_rmw = 1'b0;
    chk8({7'h00, sfr_rvalid}, 8'h01);
    chk8(sfr_rdata, exp);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  // hang guard, well beyond the hundred or so cycles the tests need
  initial begin
    #20000;
    miscompares++;
    test_done();
  end

  initial begin
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    // reset state
    rdchk(ADDR_P4_MODE, PAGE_HIGH, 1'b0, MODE_RST);
    rdchk(ADDR_P5_MODE, PAGE_HIGH, 1'b0, MODE_RST);
    rdchk(ADDR_P2_MODE, PAGE_HIGH, 1'b0, MODE_RST);
    rdchk(ADDR_P4_LATCH, PAGE_HIGH, 1'b1, LATCH_RST);
    chk8(port2_drive_mode, 8'h00);
    chk8(pin_oe_n[IDX_P4], 8'hFF);
    chk8(pin_pu[IDX_P4], 8'hFF);
    // port 3 written from page zero
    wr(ADDR_P3_LATCH, 8'h00, 8'h00);
    idle(2);
    chk8(pin_out[IDX_P3], 8'h00);
    chk8(pin_oe_n[IDX_P3], 8'h00);
    chk8(pin_pu[IDX_P3], 8'h00);
    // the pin filter needs a few more edges before a normal read sees the new level
    idle(2);
    rdchk(ADDR_P3_LATCH, 8'h00, 1'b0, 8'h00);
    wr(ADDR_P2_MODE, PAGE_HIGH, 8'h5A);
    idle(1);
    chk8(port2_drive_mode, 8'h5A);
    // mixed styles on port 4
    wr(ADDR_P4_MODE, PAGE_HIGH, 8'hF0);
    wr(ADDR_P4_LATCH, PAGE_HIGH, 8'hA5);
    idle(2);
    chk8(pin_oe_n[IDX_P4], 8'h05);
    chk8(pin_out[IDX_P4] & 8'hFA, 8'hA0);
    chk8(pin_pu[IDX_P4], 8'hA5);
    idle(4);
    rdchk(ADDR_P4_LATCH, PAGE_HIGH, 1'b0, 8'hA5);
    // wrong page and unmapped places
    wr(ADDR_P4_LATCH, 8'h00, 8'h00);
    rdchk(ADDR_P4_LATCH, PAGE_HIGH, 1'b1, 8'hA5);
    rdchk(ADDR_P4_LATCH, 8'h00, 1'b1, 8'h00);
    rdchk(8'h55, PAGE_HIGH, 1'b0, 8'h00);
    // forced open-drain and global pull-up disable
    force_open_drain[IDX_P4] = 8'hFF;
    idle(2);
    chk8(pin_oe_n[IDX_P4], 8'hA5);
    force_open_drain[IDX_P4] = 8'h00;
    pullup_global_disable = 1'b1;
    idle(2);
    chk8(pin_pu[IDX_P4], 8'h00);
    pullup_global_disable = 1'b0;
    // bit access on port 5, bit write to a mode register ignored
    wr(ADDR_P5_LATCH, PAGE_HIGH, 8'h3C);
    bwr(ADDR_P5_LATCH, PAGE_HIGH, 3'd7, 1'b1);
    bwr(ADDR_P5_LATCH, PAGE_HIGH, 3'd2, 1'b0);
    rdchk(ADDR_P5_LATCH, PAGE_HIGH, 1'b1, 8'hB8);
    bwr(ADDR_P4_MODE, PAGE_HIGH, 3'd0, 1'b1);
    rdchk(ADDR_P4_MODE, PAGE_HIGH, 1'b0, 8'hF0);
    idle(4);
    rdchk(ADDR_P5_LATCH, PAGE_HIGH, 1'b0, 8'hB8);
    // port 3 as digital input driven from outside
    wr(ADDR_P3_LATCH, 8'h00, 8'hFF);
    ext_val[IDX_P3] = 8'h5A;
    ext_en[IDX_P3] = 8'hFF;
    idle(4);
    rdchk(ADDR_P3_LATCH, 8'h00, 1'b0, 8'h5A);
    rdchk(ADDR_P3_LATCH, 8'h00, 1'b1, 8'hFF);
    ext_en[IDX_P3] = 8'h00;
    // memory interface takeover, read then write, mux then non-mux
    port3_drive_mode = 8'hFF;
    external_memory_interface_active = 1'b1;
    external_memory_interface_read = 1'b1;
    external_memory_interface_mux = 1'b1;
    external_memory_interface_wr_n = 1'b0;
    external_memory_interface_ale = 1'b1;
    external_memory_interface_ad = 8'h3C;
    idle(2);
    chk8(pin_oe_n[IDX_P3], 8'hFF);
    chk8(pin_out[IDX_P4] & 8'hE0, 8'h60);
    chk8(pin_oe_n[IDX_P4] & 8'hE0, 8'h00);
    external_memory_interface_read = 1'b0;
    idle(2);
    chk8(pin_out[IDX_P3], 8'h3C);
    chk8(pin_oe_n[IDX_P3], 8'h00);
    external_memory_interface_mux = 1'b0;
    external_memory_interface_addr_hi = 8'h81;
    idle(2);
    chk8(pin_out[IDX_P5], 8'h81);
    external_memory_interface_active = 1'b0;
    idle(2);
    chk8(pin_out[IDX_P3], 8'hFF);
    // zeroed latch on a port without pins, then a second reset
    wr(ADDR_P5_LATCH, PAGE_HIGH, BYTE_ZERO);
    idle(2);
    chk8(pin_oe_n[IDX_P5], 8'h00);
    rst_n = 1'b0;
    idle(2);
    rst_n = 1'b1;
    rdchk(ADDR_P4_MODE, PAGE_HIGH, 1'b0, MODE_RST);
    rdchk(ADDR_P5_LATCH, PAGE_HIGH, 1'b1, LATCH_RST);
    test_done();
  end
endmodule
